// ---- design/node_state_network_mgmt.sv ----
// module: three-node network-management state machine with announce and heartbeat
module node_state_network_mgmt #(
  parameter int unsigned INIT_CYCLES = nmt_pkg::INIT_MS * nmt_pkg::CYC_PER_MS,
  parameter int unsigned CNT_W       = 26
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  scan_done,          // preliminary scan of all channels finished
  input  wire logic [6:0]            start_address,      // first source node address
  input  wire logic [8:0]            hb_period_ms,       // heartbeat period, 0 selects default
  input  wire logic                  rx_valid,           // one-cycle received frame strobe
  input  wire nmt_pkg::rx_frame_t    rx_frame,           // received standard frame
  input  wire logic                  tx_ready,           // frame transmitter accepts
  output logic                       tx_valid,           // frame offered
  output nmt_pkg::tx_frame_t         tx_frame,           // announce or heartbeat frame
  output logic [2:0]                 run_mask,           // per-node data frames enabled
  output logic                       config_allowed,     // service tool may configure
  output logic                       bus_enable          // network traffic permitted
);
  import nmt_pkg::*;

  // heartbeat periods in clock cycles; the shared timer must hold the
  // longest of them, so CNT_W is checked against the maximum below
  localparam int unsigned HB_DEF_CYC = HB_DEF_MS * CYC_PER_MS;
  localparam int unsigned HB_MAX_CYC = HB_MAX_MS * CYC_PER_MS;

  // refuse counter widths that cannot reach the dwell or the period;
  // a short counter would wrap and leave initialization far too early
  initial begin
    if (INIT_CYCLES < 1 || INIT_CYCLES >= (64'd1 << CNT_W))
      $error("INIT_CYCLES does not fit CNT_W");
    if (HB_MAX_CYC >= (64'd1 << CNT_W))
      $error("heartbeat period does not fit CNT_W");
  end

  // per-node machines share the timers but keep their own state and
  // their own owed-frame flags, so each node answers only its own commands and the broadcast standby
  node_state_t            state_r [NUM_NODES];  // per-node state
  logic [NUM_NODES-1:0]   boot_pend_r;          // announce still owed
  logic [NUM_NODES-1:0]   hb_pend_r;            // heartbeat owed
  logic [CNT_W-1:0]       init_cnt_r;           // initialization timer
  logic                   init_done_r;          // dwell elapsed and scan done
  logic [CNT_W-1:0]       hb_cnt_r;             // heartbeat period timer
  logic [CNT_W-1:0]       hb_limit;             // selected period in cycles
  logic                   hb_tick;              // period elapsed
  logic                   cmd_ok;               // well-formed command frame
  logic [1:0]             sel;                  // node chosen for transmit
  logic                   any_pend;             // some frame owed
  logic [6:0]             node_addr [NUM_NODES]; // source address of each node
  logic [NUM_NODES-1:0]   announced;            // announce sent for node

  // heartbeat period, clamped to the longest allowed
  always_comb begin
    if (hb_period_ms == '0)
      hb_limit = CNT_W'(HB_DEF_CYC);
    else if (32'(hb_period_ms) > HB_MAX_MS)
      hb_limit = CNT_W'(HB_MAX_CYC);
    else
      hb_limit = CNT_W'(32'(hb_period_ms) * CYC_PER_MS);
  end

  // commands are dropped until every node has had its announce accepted,
  // so nothing is taken from the network ahead of the announce frames
  // frame filter: id 0, length 2, known command byte
  assign cmd_ok = rx_valid && init_done_r && (announced == '1) && rx_frame.id == NMT_ID
                  && rx_frame.dlc == CMD_DLC
                  && (rx_frame.b0 == CMD_RUN || rx_frame.b0 == CMD_STANDBY);

  // the dwell runs first; a scan that finishes early is simply waited on,
  // a late scan holds the block in initialization as long as it takes
  // initialization timer waits dwell then scan completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_r  <= '0;
      init_done_r <= 1'b0;
    end else if (!init_done_r) begin
      if (init_cnt_r < CNT_W'(INIT_CYCLES - 1))
        init_cnt_r <= init_cnt_r + 1'b1;
      else if (scan_done)
        init_done_r <= 1'b1;
    end
  end

  // one timer for all nodes keeps the three heartbeats together; a period
  // change takes effect at once because the compare is against hb_limit
  // shared heartbeat timer, runs once nodes leave initialization
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      hb_cnt_r <= '0;
    else if (!init_done_r || hb_tick)
      hb_cnt_r <= '0;
    else
      hb_cnt_r <= hb_cnt_r + 1'b1;
  end
  assign hb_tick = init_done_r && (hb_cnt_r >= hb_limit - 1'b1);

  // fixed priority is enough here: each node owes at most one frame of
  // each kind, so no node can starve the others
  // transmit arbiter: lowest node first, announce before heartbeat
  always_comb begin
    sel      = 2'd0;
    any_pend = 1'b0;
    for (int i = NUM_NODES - 1; i >= 0; i--) begin
      if (boot_pend_r[i] || hb_pend_r[i]) begin
        sel      = 2'(i);
        any_pend = 1'b1;
      end
    end
  end

  // one independent state machine per source address
  genvar g;
  generate
    for (g = 0; g < NUM_NODES; g++) begin : g_node
      logic hit;   // command addressed to this node
      logic sent;  // this node's frame accepted now
      always_comb begin
        node_addr[g] = start_address + 7'(g);
        if (node_addr[g] > 7'd75)
          node_addr[g] = node_addr[g] - 7'd10;  // wraps within the node address window
      end
      assign hit  = rx_frame.b1 == {1'b0, node_addr[g]};
      assign sent = tx_valid && tx_ready && sel == 2'(g);
      assign announced[g] = state_r[g] != ST_INIT && !boot_pend_r[g];

      // standby and run persist; only an accepted command moves them, and
      // an unknown encoding falls back to initialization
      // state transitions: init leaves on init_done_r, standby and run on command frames only
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          state_r[g] <= ST_INIT;
        else begin
          case (state_r[g])
            ST_INIT: begin
              if (init_done_r)
                state_r[g] <= ST_STANDBY;
            end
            ST_STANDBY: begin
              if (cmd_ok && rx_frame.b0 == CMD_RUN && hit)
                state_r[g] <= ST_RUN;
            end
            ST_RUN: begin
              if (cmd_ok && rx_frame.b0 == CMD_STANDBY && (hit || rx_frame.b1 == ADDR_ALL))
                state_r[g] <= ST_STANDBY;
            end
            default: state_r[g] <= ST_INIT;
          endcase
        end
      end

      // announce owed on leaving initialization
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          boot_pend_r[g] <= 1'b0;
        else if (state_r[g] == ST_INIT && init_done_r)
          boot_pend_r[g] <= 1'b1;
        else if (sent)
          boot_pend_r[g] <= 1'b0;
      end

      // heartbeat owed each period; new tick wins over clear
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          hb_pend_r[g] <= 1'b0;
        else if (hb_tick && state_r[g] != ST_INIT)
          hb_pend_r[g] <= 1'b1;
        else if (sent && !boot_pend_r[g])
          hb_pend_r[g] <= 1'b0;
      end

      assign run_mask[g] = state_r[g] == ST_RUN;
    end
  endgenerate

  // the frame is rebuilt every cycle from the current owner; while a frame
  // is held waiting for tx_ready the owner still changes if a lower node becomes owed
  // offered frame registered from the selected node
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tx_frame <= '0;
    else begin
      tx_frame.id  <= ANNOUNCE_BASE + {4'h0, node_addr[sel]};
      tx_frame.dlc <= HB_DLC;
      if (boot_pend_r[sel])
        tx_frame.b0 <= ST_CODE_BOOT;
      else if (state_r[sel] == ST_RUN)
        tx_frame.b0 <= ST_CODE_RUN;
      else
        tx_frame.b0 <= ST_CODE_STBY;
    end
  end

  // after each acceptance valid drops for one cycle so the register can
  // load the next owner's frame before it is offered
  // valid is registered alongside the frame, so both appear one cycle after selection
  logic offer_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      offer_r <= 1'b0;
    else
      offer_r <= any_pend && !(tx_valid && tx_ready);
  end
  assign tx_valid = offer_r && any_pend;

  // status outputs: traffic allowed once initialization is over, service
  // configuration only while every node is announced and in standby
  assign bus_enable     = init_done_r;
  assign config_allowed = (run_mask == '0) && (announced == '1);
endmodule // node_state_network_mgmt

// ---- design/nmt_pkg.sv ----
// package: network-management constants, states and frame carriers
package nmt_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned INIT_MS       = 3000;           // initialization dwell
  localparam int unsigned HB_DEF_MS     = 300;            // heartbeat default period
  localparam int unsigned HB_MAX_MS     = 500;            // longest heartbeat period
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;  // cycles per millisecond
  localparam int unsigned NUM_CHANNELS  = 22;             // channels of preliminary scan
  localparam int unsigned NUM_NODES     = 3;              // independent state machines
  localparam logic [10:0] NMT_ID        = 11'h000;        // command identifier
  localparam logic [10:0] ANNOUNCE_BASE = 11'h700;        // announce/heartbeat id base
  localparam logic [7:0]  CMD_RUN       = 8'h01;          // enter-run command byte
  localparam logic [7:0]  CMD_STANDBY   = 8'h80;          // enter-standby command byte
  localparam logic [7:0]  ADDR_ALL      = 8'h00;          // broadcast node address
  localparam logic [3:0]  CMD_DLC       = 4'h2;           // command data length
  localparam logic [3:0]  HB_DLC        = 4'h1;           // announce/heartbeat length
  localparam logic [7:0]  ST_CODE_BOOT  = 8'h00;          // announce payload
  localparam logic [7:0]  ST_CODE_RUN   = 8'h05;          // heartbeat payload, run
  localparam logic [7:0]  ST_CODE_STBY  = 8'h7F;          // heartbeat payload, standby

  // per-node state, one-hot
  typedef enum logic [2:0] {
    ST_INIT    = 3'b001,
    ST_STANDBY = 3'b010,
    ST_RUN     = 3'b100
  } node_state_t;

  // received standard frame
  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [7:0]  b0;
    logic [7:0]  b1;
  } rx_frame_t;

  // outgoing one-byte error-control frame
  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [7:0]  b0;
  } tx_frame_t;
endpackage

// ---- testbench/nmt_sva.sv ----
// checker: port assertions of the network-management block
module nmt_sva
  import nmt_pkg::*;
#(parameter int unsigned INIT_CYCLES = 20) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               scan_done,
  input wire logic [6:0]         start_address,
  input wire logic               rx_valid,
  input wire nmt_pkg::rx_frame_t rx_frame,
  input wire logic               tx_valid,
  input wire nmt_pkg::tx_frame_t tx_frame,
  input wire logic [2:0]         run_mask,
  input wire logic               bus_enable
);
  logic [31:0] up_r; // cycles since reset release
  logic        cmd;  // well-formed command frame
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign cmd = rx_valid && rx_frame.id == NMT_ID && rx_frame.dlc == CMD_DLC
    && rx_frame.b0 inside {CMD_RUN, CMD_STANDBY};
  // saturating age counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_r <= 32'h0;
    else if (!(&up_r)) up_r <= up_r + 32'h1;
  end
  a_init_quiet: assert property (!bus_enable |-> !tx_valid && run_mask == 3'h0)
    else $error("traffic during init");
  a_init_dwell: assert property (bus_enable |-> up_r >= INIT_CYCLES)
    else $error("init left early");
  a_scan_gate: assert property ($rose(bus_enable) |-> $past(scan_done))
    else $error("init left before scan");
  a_frame_id: assert property (tx_valid |-> tx_frame.id[10:7] == 4'hE && tx_frame.dlc == HB_DLC)
    else $error("bad frame id or length");
  a_state_code: assert property (tx_valid |-> tx_frame.b0 inside {8'h00, 8'h05, 8'h7F})
    else $error("bad state code");
  a_state_hold: assert property (!cmd |=> $stable(run_mask))
    else $error("state moved without command");
  a_bcast_stop: assert property (cmd && rx_frame.b0 == CMD_STANDBY && rx_frame.b1 == 8'h00
    |=> run_mask == 3'h0)
    else $error("broadcast standby missed");
  a_run_addr: assert property ($rose(run_mask[0]) |-> $past(cmd && rx_frame.b1 == {1'b0, start_address}))
    else $error("run without own address");
endmodule // nmt_sva

// ---- testbench/sup_model.sv ----
// partner: supervising controller sending commands and taking frames
module sup_model
  import nmt_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               slow,     // take one frame in four cycles
  input  wire logic               tx_valid,
  input  wire nmt_pkg::tx_frame_t tx_frame,
  output logic                    rx_valid,
  output nmt_pkg::rx_frame_t      rx_frame,
  output logic                    tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  tx_frame_t  got[$];       // frames taken, oldest first
  logic [1:0] div_r = 2'h0; // stall divider
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_ready = 1'b0;
  end
  // take offered frames, stalling when asked
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_frame);
    div_r <= div_r + 2'h1;
    tx_ready <= #1 !slow || div_r == 2'h0;
  end
  // present one command frame for one edge
  task automatic send(input logic [10:0] id, input logic [7:0] b0, b1,
                      input logic [3:0] n = CMD_DLC);
    rx_frame = '{id, n, b0, b1};
    rx_valid = 1'b1;
    @(posedge clk) #1;
  endtask
  // release the bus; frame lines scramble
  task automatic idle();
    rx_valid = 1'b0;
    rx_frame = ~rx_frame;
    @(posedge clk) #1;
  endtask
endmodule // sup_model

// ---- testbench/tb_node_state_network_mgmt.sv ----
// testbench: boot, command and heartbeat scenarios
module tb_node_state_network_mgmt;
  timeunit 1ns;
  timeprecision 1ps;
  import nmt_pkg::*;
  localparam logic [6:0] A0 = 7'h4B; // start address, wraps after it
  logic [6:0] adr[3] = '{7'h4B, 7'h42, 7'h43}; // node addresses
  logic clk = 1'b0, rst_n, scan_done, slow, rx_valid, tx_ready, tx_valid;
  logic bus_enable, config_allowed;
  logic [2:0] run_mask;
  rx_frame_t rx_frame;
  tx_frame_t tx_frame;
  int miscompares = 0, total_checks = 0;
  time t_end; // end of the run heartbeat burst
  always #25 clk = ~clk;
  node_state_network_mgmt #(.INIT_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n),
    .scan_done(scan_done), .start_address(A0), .hb_period_ms(9'h001), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .run_mask(run_mask), .config_allowed(config_allowed), .bus_enable(bus_enable));
  sup_model sup (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_ready(tx_ready));
  // compare a value
  task automatic chk(input string what, input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare three frames, one per node
  task automatic frames(input string what, input logic [7:0] code);
    tx_frame_t f;
    tx_frame_t e;
    for (int i = 0; i < 3; i++) begin
      for (int n = 0; n < 30000 && sup.got.size() == 0; n++) @(posedge clk) #1;
      f = sup.got.size() ? sup.got.pop_front() : '0;
      e = tx_frame_t'({ANNOUNCE_BASE + adr[i], HB_DLC, code});
      total_checks++;
      if (f !== e) begin
        miscompares++;
        $display("BAD %s expected %h seen %h", what, e, f);
      end
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // boot: held in init until scan, then three announces
  task automatic t_boot();
    repeat (30) @(posedge clk);
    #1 chk("frames before scan", 8'(sup.got.size()), 8'h00);
    scan_done = 1'b1;
    frames("announce", ST_CODE_BOOT);
    @(posedge clk) #1 chk("config standby", {7'h0, config_allowed}, 8'h01);
  endtask
  // commands: malformed ignored, run per address
  task automatic t_run();
    sup.send(11'h001, CMD_RUN, 8'h42);
    sup.send(NMT_ID, CMD_RUN, 8'h42, 4'h3);
    sup.send(NMT_ID, 8'h02, 8'h42);
    sup.send(NMT_ID, CMD_RUN, 8'h46);
    sup.idle();
    chk("mask ignored", {5'h0, run_mask}, 8'h00);
    sup.send(NMT_ID, CMD_RUN, 8'h42);
    sup.idle();
    chk("mask one", {5'h0, run_mask}, 8'h02);
    chk("config run", {7'h0, config_allowed}, 8'h00);
    sup.send(NMT_ID, CMD_RUN, 8'h4B);
    sup.send(NMT_ID, CMD_RUN, 8'h43);
    sup.idle();
    chk("mask all", {5'h0, run_mask}, 8'h07);
    slow = 1'b1;
    frames("hb run", ST_CODE_RUN);
    slow = 1'b0;
    t_end = $time;
  endtask
  // standby: addressed then broadcast, heartbeat spacing
  task automatic t_standby();
    sup.send(NMT_ID, CMD_STANDBY, 8'h43);
    sup.idle();
    chk("mask addressed", {5'h0, run_mask}, 8'h03);
    sup.send(NMT_ID, CMD_STANDBY, ADDR_ALL);
    sup.idle();
    chk("mask broadcast", {5'h0, run_mask}, 8'h00);
    frames("hb standby", ST_CODE_STBY);
    chk("hb period", {7'h0, ($time - t_end) / 50 inside {[19950:20050]}}, 8'h01);
  endtask
  // mid-run reset: silent again until a new scan, then announces anew
  task automatic t_reset();
    scan_done = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (30) @(posedge clk);
    #1 chk("bus after reset", {7'h0, bus_enable}, 8'h00);
    chk("mask after reset", {5'h0, run_mask}, 8'h00);
    chk("frames after reset", 8'(sup.got.size()), 8'h00);
    scan_done = 1'b1;
    frames("announce again", ST_CODE_BOOT);
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    scan_done = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_boot();
    t_run();
    t_standby();
    t_reset();
    finish_test();
  end
endmodule // tb_node_state_network_mgmt
bind node_state_network_mgmt nmt_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (.clk(clk),
  .rst_n(rst_n), .scan_done(scan_done), .start_address(start_address),
  .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame),
  .run_mask(run_mask), .bus_enable(bus_enable));
